// *** sqr_map.svh ***
`ifndef SQR_MAP_SVH
`define SQR_MAP_SVH
// Opcodes
`define SQR_OP_SEC_PROG 8'h42
`define SQR_OP_SEC_READ 8'h48
`define SQR_OP_SET_PARAM 8'hc0
`define SQR_OP_BURST_WRAP 8'h0c
`define SQR_OP_ENTER_QPI 8'h38
`define SQR_OP_EXIT_QPI 8'hff
// Security register address fields
`define SQR_ADDR_TOP 8'h00
`define SQR_ADDR_MID 4'h0
`define SQR_SEL_MAX 4'h3
`define SQR_ERASED 8'hff
// Bit counts on the link
`define SQR_OPC_BITS 6'h08
`define SQR_ADDR_BITS 6'h20
`define SQR_SEC_DUMMY 4'h8
// Power-up read parameter defaults
`define SQR_DUMMY_DEF 2'h0
`define SQR_WRAP_DEF 2'h0
// Self-timed program cycle
`define SQR_PROG_TIME_US 10
`define SQR_CLK_MHZ 10
`define SQR_PROG_CYC (`SQR_PROG_TIME_US * `SQR_CLK_MHZ)
`endif

// *** sqr_pkg.sv ***
package sqr_pkg;
    typedef enum logic [2:0] {
        ST_OPC, ST_ADDR, ST_PARAM, ST_DUMMY, ST_PDATA, ST_RDATA, ST_BDATA, ST_IGN
    } sqr_state_t;
    // Raw pin levels from the host
    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic [3:0] io;
    } sqr_pins_t;
    // Drive onto the four data lanes
    typedef struct packed {
        logic [3:0] dout;
        logic [3:0] oe;
    } sqr_drive_t;
    // Read parameters in force for QPI reads
    typedef struct packed {
        logic [1:0] dummy_count_field;
        logic [1:0] wrap_size_field;
    } sqr_cfg_t;
endpackage

// *** sqr_cmd.sv ***
// What this block does
// - Program accepted only with write latch set
// - Program one to 256 bytes over erased
// - Address decode picks register and byte offset
// - Locked register ignores program
// - Read 48h: address, eight dummies, rising sample
// - Read data out on falling edges, MSB first
// - Read offset wraps inside same register
// - Chip select high ends the read
// - Read while busy is ignored
// - Out-of-range read returns FFh
// - C0h accepted only in QPI mode
// - Bits 5:4 select 2/4/6/8 dummy clocks
// - Bits 1:0 select 8/16/32/64 byte wrap
// - Reset defaults: wrap 8, dummies 2
// - SPI wrap from 77h setting, kept entering QPI
// - 0Ch burst wraps in aligned window
// - Only 38h moves SPI into QPI
// - Power-up starts in SPI mode
// - 38h ignored unless quad enable set
// - Entering QPI keeps latch, suspend, wrap
// - FFh returns QPI to SPI
// - Busy high during self-timed program
`include "sqr_map.svh"
`timescale 1ns/1ps
`default_nettype none

module sqr_cmd #(
    parameter int unsigned PROG_CYC = `SQR_PROG_CYC
) (
    input wire logic ref_clk, // 10 MHz system clock
    input wire logic rst, // Async reset, high
    input wire sqr_pkg::sqr_pins_t pins, // Raw host pins
    input wire logic write_permit_latch, // Write enable latch
    input wire logic busy_in, // Other self-timed cycles
    input wire logic [2:0] otp_lock_bits, // Per-register lock
    input wire logic quad_lanes_allow_bit, // Quad enable
    input wire logic [1:0] spi_wrap_size_field, // Wrap from 77h
    input wire logic soft_rst, // Reset command pulse
    input wire logic [7:0] arr_data, // Main array byte
    output sqr_pkg::sqr_drive_t pin_drv_r, // Lane drive
    output sqr_pkg::sqr_cfg_t cfg_r, // Read parameters
    output logic qpi_mode_r, // High in QPI mode
    output logic busy_r, // Busy status bit
    output logic [23:0] arr_addr_r // Main array address
);

////////////////////////////////////////////////////////////////////////////
// Decode helpers

    // Register number 1..3, or 0 when outside the map
    function automatic logic [1:0] sec_sel(input logic [23:0] a);
        logic ok;
        ok = a[23:16] == `SQR_ADDR_TOP && a[11:8] == `SQR_ADDR_MID;
        ok = ok && a[15:12] != 4'h0 && a[15:12] <= `SQR_SEL_MAX;
        return ok ? a[13:12] : 2'h0;
    endfunction

////////////////////////////////////////////////////////////////////////////
// Pin synchronisers

    sqr_pkg::sqr_pins_t pins_s1_r;
    sqr_pkg::sqr_pins_t pins_s2_r;
    logic sclk_d_r;

    // Two stages before anything reads the pins
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pins_s1_r <= '{cs_n: 1'b1, sclk: 1'b0, io: 4'h0};
            pins_s2_r <= '{cs_n: 1'b1, sclk: 1'b0, io: 4'h0};
            sclk_d_r <= 1'b0;
        end else begin
            pins_s1_r <= pins;
            pins_s2_r <= pins_s1_r;
            sclk_d_r <= pins_s2_r.sclk;
        end
    end

////////////////////////////////////////////////////////////////////////////
// State and storage

    sqr_pkg::sqr_state_t st_r, st_nxt;
    sqr_pkg::sqr_drive_t drv_nxt;
    sqr_pkg::sqr_cfg_t cfg_nxt;
    logic [7:0] cmd_r, cmd_nxt;
    logic qpi_nxt;
    logic [5:0] bits_r, bits_nxt;
    logic [31:0] sh_r, sh_nxt;
    logic [23:0] addr_r, addr_nxt;
    logic [3:0] dcnt_r, dcnt_nxt;
    logic [2:0] bp_r, bp_nxt;
    logic nib_r, nib_nxt;
    logic pwr_r, pwr_nxt;
    logic [15:0] ptim_r, ptim_nxt;
    logic [767:0] prog_r;
    logic [7:0] mem [0:767];

    // Edges only count while chip select is low
    wire cs_hi = pins_s2_r.cs_n;
    wire sclk_rise = !cs_hi && pins_s2_r.sclk && !sclk_d_r;
    wire sclk_fall = !cs_hi && !pins_s2_r.sclk && sclk_d_r;
    wire [2:0] lane_w = qpi_mode_r ? 3'h4 : 3'h1;
    wire [31:0] sh_in = qpi_mode_r ? {sh_r[27:0], pins_s2_r.io} : {sh_r[30:0], pins_s2_r.io[0]};
    wire [5:0] bits_inc = bits_r + {3'h0, lane_w};
    wire opc_done = sclk_rise && st_r == sqr_pkg::ST_OPC && bits_inc == `SQR_OPC_BITS;
    wire [7:0] opc = sh_in[7:0];

    // Security register lookup at the running address
    wire [1:0] rd_sel = sec_sel(addr_r);
    wire [1:0] sel_m1 = rd_sel - 2'h1;
    wire [9:0] mem_idx = {sel_m1, addr_r[7:0]};
    wire stored = rd_sel != 2'h0 && prog_r[mem_idx];
    wire [7:0] cur_byte = stored ? mem[mem_idx] : `SQR_ERASED;
    wire cur_bit = cur_byte[bp_r];
    wire lock_hit = otp_lock_bits[sel_m1];
    wire byte_in = sclk_rise && st_r == sqr_pkg::ST_PDATA && bits_inc == `SQR_OPC_BITS;
    wire mem_we = byte_in && rd_sel != 2'h0 && !lock_hit;
    // Programming only clears bits, as on erased cells
    wire [7:0] mem_wd = cur_byte & sh_in[7:0];

    // Dummy clocks: 2 + 2 * field in QPI, 8 for 48h
    wire [3:0] dummy_need = (cmd_r == `SQR_OP_SEC_READ) ? `SQR_SEC_DUMMY :
        {1'b0, cfg_r.dummy_count_field, 1'b0} + 4'h2;
    wire [3:0] dcnt_inc = dcnt_r + 4'h1;

    // Burst wrap inside an aligned 8/16/32/64 byte window
    wire [7:0] wrap_mask = (8'h08 << cfg_r.wrap_size_field) - 8'h01;
    wire [7:0] lo_inc = addr_r[7:0] + 8'h01;
    wire [23:0] burst_next = {addr_r[23:8],
        (addr_r[7:0] & ~wrap_mask) | (lo_inc & wrap_mask)};

////////////////////////////////////////////////////////////////////////////
// Command sequencer

    // Rising edges shift in, falling edges shift out
    always_comb begin
        st_nxt = st_r;
        cmd_nxt = cmd_r;
        qpi_nxt = qpi_mode_r;
        bits_nxt = bits_r;
        sh_nxt = sh_r;
        addr_nxt = addr_r;
        dcnt_nxt = dcnt_r;
        bp_nxt = bp_r;
        nib_nxt = nib_r;
        pwr_nxt = pwr_r;
        drv_nxt = pin_drv_r;
        cfg_nxt = cfg_r;
        ptim_nxt = (ptim_r != 16'h0) ? ptim_r - 16'h1 : 16'h0;
        if (soft_rst) begin
            cfg_nxt = '{dummy_count_field: `SQR_DUMMY_DEF,
                wrap_size_field: `SQR_WRAP_DEF};
        end
        if (cs_hi) begin
            // Chip select high ends any command
            st_nxt = sqr_pkg::ST_OPC;
            bits_nxt = 6'h0;
            drv_nxt.oe = 4'h0;
            bp_nxt = 3'h7;
            nib_nxt = 1'b0;
            pwr_nxt = 1'b0;
            if (st_r == sqr_pkg::ST_PDATA && pwr_r) begin
                ptim_nxt = 16'(PROG_CYC);
            end
        end else if (sclk_rise) begin
            sh_nxt = sh_in;
            bits_nxt = bits_inc;
            unique case (st_r)
                sqr_pkg::ST_OPC: begin
                    if (bits_inc == `SQR_OPC_BITS) begin
                        cmd_nxt = opc;
                        st_nxt = sqr_pkg::ST_IGN;
                        unique case (opc)
                            `SQR_OP_SEC_PROG: begin
                                if (!qpi_mode_r && write_permit_latch && !busy_r) begin
                                    st_nxt = sqr_pkg::ST_ADDR;
                                end
                            end
                            `SQR_OP_SEC_READ: begin
                                if (!qpi_mode_r && !busy_r) begin
                                    st_nxt = sqr_pkg::ST_ADDR;
                                end
                            end
                            `SQR_OP_BURST_WRAP: begin
                                if (qpi_mode_r && !busy_r) begin
                                    st_nxt = sqr_pkg::ST_ADDR;
                                end
                            end
                            `SQR_OP_SET_PARAM: begin
                                if (qpi_mode_r) begin
                                    st_nxt = sqr_pkg::ST_PARAM;
                                    bits_nxt = 6'h0;
                                end
                            end
                            `SQR_OP_ENTER_QPI: begin
                                // Latch, suspend state kept; wrap taken from 77h
                                if (!qpi_mode_r && quad_lanes_allow_bit) begin
                                    qpi_nxt = 1'b1;
                                    cfg_nxt.wrap_size_field = spi_wrap_size_field;
                                end
                            end
                            `SQR_OP_EXIT_QPI: begin
                                if (qpi_mode_r) begin
                                    qpi_nxt = 1'b0;
                                end
                            end
                            default: begin
                            end
                        endcase
                    end
                end
                sqr_pkg::ST_ADDR: begin
                    if (bits_inc == `SQR_ADDR_BITS) begin
                        addr_nxt = sh_in[23:0];
                        dcnt_nxt = 4'h0;
                        bits_nxt = 6'h0;
                        st_nxt = (cmd_r == `SQR_OP_SEC_PROG) ? sqr_pkg::ST_PDATA :
                            sqr_pkg::ST_DUMMY;
                    end
                end
                sqr_pkg::ST_DUMMY: begin
                    dcnt_nxt = dcnt_inc;
                    if (dcnt_inc == dummy_need) begin
                        st_nxt = (cmd_r == `SQR_OP_SEC_READ) ? sqr_pkg::ST_RDATA :
                            sqr_pkg::ST_BDATA;
                    end
                end
                sqr_pkg::ST_PARAM: begin
                    if (bits_inc == `SQR_OPC_BITS) begin
                        cfg_nxt = '{dummy_count_field: sh_in[5:4],
                            wrap_size_field: sh_in[1:0]};
                        st_nxt = sqr_pkg::ST_IGN;
                    end
                end
                sqr_pkg::ST_PDATA: begin
                    // Offset wraps in the register, up to 256 bytes
                    if (bits_inc == `SQR_OPC_BITS) begin
                        bits_nxt = 6'h0;
                        addr_nxt[7:0] = lo_inc;
                        pwr_nxt = pwr_r | mem_we;
                    end
                end
                sqr_pkg::ST_RDATA, sqr_pkg::ST_BDATA, sqr_pkg::ST_IGN: begin
                    bits_nxt = bits_r;
                end
            endcase
        end else if (sclk_fall && st_r == sqr_pkg::ST_RDATA) begin
            drv_nxt.dout = {2'h0, cur_bit, 1'b0};
            drv_nxt.oe = 4'h2;
            bp_nxt = bp_r - 3'h1;
            if (bp_r == 3'h0) begin
                addr_nxt[7:0] = lo_inc;
            end
        end else if (sclk_fall && st_r == sqr_pkg::ST_BDATA) begin
            drv_nxt.dout = nib_r ? arr_data[3:0] : arr_data[7:4];
            drv_nxt.oe = 4'hf;
            nib_nxt = !nib_r;
            if (nib_r) begin
                addr_nxt = burst_next;
            end
        end
    end

    // Sequencer registers; power-up is SPI with default parameters
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_r <= sqr_pkg::ST_OPC;
            cmd_r <= 8'h00;
            qpi_mode_r <= 1'b0;
            bits_r <= 6'h0;
            sh_r <= 32'h0;
            addr_r <= 24'h0;
            dcnt_r <= 4'h0;
            bp_r <= 3'h7;
            nib_r <= 1'b0;
            pwr_r <= 1'b0;
            ptim_r <= 16'h0;
            busy_r <= 1'b0;
            pin_drv_r <= '0;
            cfg_r <= '{dummy_count_field: `SQR_DUMMY_DEF,
                wrap_size_field: `SQR_WRAP_DEF};
            arr_addr_r <= 24'h0;
        end else begin
            st_r <= st_nxt;
            cmd_r <= cmd_nxt;
            qpi_mode_r <= qpi_nxt;
            bits_r <= bits_nxt;
            sh_r <= sh_nxt;
            addr_r <= addr_nxt;
            dcnt_r <= dcnt_nxt;
            bp_r <= bp_nxt;
            nib_r <= nib_nxt;
            pwr_r <= pwr_nxt;
            ptim_r <= ptim_nxt;
            busy_r <= busy_in || ptim_nxt != 16'h0;
            pin_drv_r <= drv_nxt;
            cfg_r <= cfg_nxt;
            arr_addr_r <= addr_nxt;
        end
    end

    // Written-byte map; unwritten bytes read as erased
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            prog_r <= '0;
        end else if (mem_we) begin
            prog_r[mem_idx] <= 1'b1;
        end
    end

    // Storage itself has no reset; the map covers it
    always_ff @(posedge ref_clk) begin
        if (mem_we) begin
            mem[mem_idx] <= mem_wd;
        end
    end

////////////////////////////////////////////////////////////////////////////
// Checks

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    property p_prog_wel;
        opc_done && opc == `SQR_OP_SEC_PROG && !write_permit_latch |=> st_r == sqr_pkg::ST_IGN;
    endproperty
    a_prog_wel: assert property (p_prog_wel) else $error("program taken without latch");
    property p_lock;
        mem_we |-> !otp_lock_bits[sel_m1];
    endproperty
    a_lock: assert property (p_lock) else $error("locked register written");
    property p_decode;
        mem_we |-> addr_r[23:16] == 8'h00 && addr_r[11:8] == 4'h0;
    endproperty
    a_decode: assert property (p_decode) else $error("write outside map");
    property p_msb;
        sclk_fall && st_r == sqr_pkg::ST_RDATA
            |=> pin_drv_r.dout[1] == $past(cur_bit) && pin_drv_r.oe[1];
    endproperty
    a_msb: assert property (p_msb) else $error("read bit wrong");
    property p_wrap8;
        sclk_fall && st_r == sqr_pkg::ST_RDATA && bp_r == 3'h0 && addr_r[7:0] == 8'hff
            |=> addr_r[7:0] == 8'h00 && rd_sel == $past(rd_sel);
    endproperty
    a_wrap8: assert property (p_wrap8) else $error("offset wrap wrong");
    property p_cs_end;
        cs_hi |=> st_r == sqr_pkg::ST_OPC && pin_drv_r.oe == 4'h0;
    endproperty
    a_cs_end: assert property (p_cs_end) else $error("command outlived select");
    property p_busy_rd;
        opc_done && opc == `SQR_OP_SEC_READ && busy_r |=> st_r == sqr_pkg::ST_IGN;
    endproperty
    a_busy_rd: assert property (p_busy_rd) else $error("read taken while busy");
    property p_oob;
        rd_sel == 2'h0 |-> cur_byte == 8'hff;
    endproperty
    a_oob: assert property (p_oob) else $error("out of map not FFh");
    property p_c0_spi;
        opc_done && opc == `SQR_OP_SET_PARAM && !qpi_mode_r |=> st_r == sqr_pkg::ST_IGN;
    endproperty
    a_c0_spi: assert property (p_c0_spi) else $error("C0h taken in SPI");
    property p_qe;
        opc_done && opc == `SQR_OP_ENTER_QPI && !quad_lanes_allow_bit |=> !qpi_mode_r;
    endproperty
    a_qe: assert property (p_qe) else $error("QPI entered without enable");
    property p_busy;
        cs_hi && st_r == sqr_pkg::ST_PDATA && pwr_r |=> busy_r [*8];
    endproperty
    a_busy: assert property (p_busy) else $error("busy not held");

    c_read: cover property (sclk_fall && st_r == sqr_pkg::ST_RDATA && bp_r == 3'h0);
    c_prog: cover property (mem_we);
    c_qpi: cover property ($rose(qpi_mode_r));
    c_burst: cover property (sclk_fall && st_r == sqr_pkg::ST_BDATA && nib_r);

endmodule

`default_nettype wire

// *** sqr_host.sv ***
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Host controller model, mode 0: serial clock parked low between frames
module sqr_host (
    input wire logic ref_clk, // Bench clock
    input wire logic [3:0] io_in, // Resolved lane levels
    output logic cs_n, // Chip select, low active
    output logic sclk, // Serial clock
    output logic [3:0] io_out, // Lanes driven by host
    output logic [3:0] io_oe // Host lane enables
);
    logic quad;
    logic [7:0] rx_byte;
    event got;
    // Idle: deselected, clock low, lanes released
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        io_out = 4'h0;
        io_oe = 4'h0;
        quad = 1'b0;
        rx_byte = 8'h00;
    end
    ////////////////////////////////////////////////////////////////////////////
    // One clock: 5 cycles low, 3 high; long low phase leaves room for the
    // device's synchroniser lag before read data is taken
    task unit(input logic [3:0] v, input logic [3:0] oe, output logic [3:0] rx);
        io_out = v;
        io_oe = oe;
        repeat (5) @(posedge ref_clk);
        rx = io_in;
        #1 sclk = 1'b1;
        repeat (3) @(posedge ref_clk);
        #1 sclk = 1'b0;
    endtask
    // One byte, high bit or high nibble first
    task xbyte(input logic [7:0] b, input logic [3:0] oe, output logic [7:0] rx);
        logic [3:0] r;
        if (quad) begin
            unit(b[7:4], oe, r);
            rx[7:4] = r;
            unit(b[3:0], oe, r);
            rx[3:0] = r;
        end else begin
            for (int i = 7; i >= 0; i--) begin
                unit({3'h0, b[i]}, oe, r);
                rx[i] = r[1];
            end
        end
    endtask
    // Read one byte with lanes released and hand it on
    task rd();
        xbyte(8'h00, 4'h0, rx_byte);
        -> got;
    endtask
    // Select stays low for the whole command
    task start(input logic q);
        @(posedge ref_clk);
        #1 cs_n = 1'b0;
        repeat (3) @(posedge ref_clk);
        #1 quad = q;
    endtask
    // Deselect ends the command; gap well over three cycles
    task stop();
        repeat (2) @(posedge ref_clk);
        #1 cs_n = 1'b1;
        io_oe = 4'h0;
        repeat (6) @(posedge ref_clk);
        #1 io_out = 4'h0;
    endtask
endmodule
`default_nettype wire

// *** sqr_cmd_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module sqr_cmd_test;
    logic ref_clk, rst, write_permit_latch, busy_in, quad_lanes_allow_bit, soft_rst;
    logic [2:0] otp_lock_bits;
    logic [1:0] spi_wrap_size_field;
    logic [3:0] junk, h_io, h_oe, hoe, r4;
    logic h_cs_n, h_sclk, qpi, busy;
    sqr_pkg::sqr_pins_t pins;
    sqr_pkg::sqr_drive_t drv;
    sqr_pkg::sqr_cfg_t cfg;
    logic [23:0] arr_addr, a;
    logic [23:0] ua[4];
    logic [7:0] arr_data, rx, m;
    logic [7:0] pd[3];
    logic [7:0] exp_q[$];
    integer seed, num_errors, num_checks, len;
    // Arbitrary array pattern, depends on both low address bytes
    function automatic logic [7:0] mem(input logic [23:0] x);
        return x[7:0] ^ x[15:8] ^ 8'h5a;
    endfunction
    // Lane level: device, then host, else a moving pattern
    assign pins = '{h_cs_n, h_sclk,
        (drv.dout & drv.oe) | (h_io & h_oe & ~drv.oe) | (junk & ~drv.oe & ~h_oe)};
    assign arr_data = mem(arr_addr);
    sqr_cmd #(.PROG_CYC(10)) u_sqr_cmd (.ref_clk(ref_clk), .rst(rst), .pins(pins),
        .write_permit_latch(write_permit_latch), .busy_in(busy_in),
        .otp_lock_bits(otp_lock_bits), .quad_lanes_allow_bit(quad_lanes_allow_bit),
        .spi_wrap_size_field(spi_wrap_size_field), .soft_rst(soft_rst),
        .arr_data(arr_data), .pin_drv_r(drv), .cfg_r(cfg), .qpi_mode_r(qpi),
        .busy_r(busy), .arr_addr_r(arr_addr));
    sqr_host u_sqr_host (.ref_clk(ref_clk), .io_in(pins.io), .cs_n(h_cs_n),
        .sclk(h_sclk), .io_out(h_io), .io_oe(h_oe));
    ////////////////////////////////////////////////////////////////////////////
    // Clock and undriven-lane noise
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) junk <= 4'($random(seed));
    task chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task results();
        if (num_errors == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Frame helpers
    task op(input logic [7:0] o, input logic q);
        hoe = q ? 4'hf : 4'h1;
        u_sqr_host.start(q);
        u_sqr_host.xbyte(o, hoe, rx);
    endtask
    task wb(input logic [7:0] b);
        u_sqr_host.xbyte(b, hoe, rx);
    endtask
    task hdr(input logic [7:0] o, input logic q, input logic [23:0] ad);
        op(o, q);
        wb(ad[23:16]);
        wb(ad[15:8]);
        wb(ad[7:0]);
    endtask
    task rdsec(input logic [23:0] ad, input int n);
        hdr(8'h48, 1'b0, ad);
        wb(8'h00);
        repeat (n) u_sqr_host.rd();
        u_sqr_host.stop();
        chk({4'h0, drv.oe}, 8'h00);
    endtask
    task prog(input logic [23:0] ad);
        hdr(8'h42, 1'b0, ad);
        foreach (pd[i]) wb(pd[i]);
        u_sqr_host.stop();
    endtask
    // Scoreboard: oldest note against each byte the host receives
    initial forever begin
        @(u_sqr_host.got);
        chk(u_sqr_host.rx_byte, exp_q.pop_front());
    end
    // Hang guard, several times the expected run
    initial begin
        repeat (80000) @(posedge ref_clk);
        num_errors++;
        results();
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        seed = 32'hf3c8;
        num_errors = 0;
        num_checks = 0;
        rst = 1'b1;
        {write_permit_latch, busy_in, quad_lanes_allow_bit, soft_rst} = 4'h0;
        otp_lock_bits = 3'h0;
        spi_wrap_size_field = 2'h1;
        repeat (12) @(posedge ref_clk);
        #1 rst = 1'b0;
        repeat (4) @(posedge ref_clk);
        chk({qpi, busy, cfg}, 8'h00);
        // Program without the latch is dropped; blank bytes read erased
        pd = '{8'ha5, 8'h3c, 8'h0f};
        prog(24'h0010fe);
        chk(busy, 8'h00);
        repeat (3) exp_q.push_back(8'hff);
        rdsec(24'h0010fe, 3);
        // Latch set by the host first; offset wraps inside register one
        write_permit_latch = 1'b1;
        foreach (pd[i]) pd[i] = 8'($random(seed));
        prog(24'h0010fe);
        chk(busy, 8'h01);
        repeat (20) @(posedge ref_clk);
        chk(busy, 8'h00);
        foreach (pd[i]) exp_q.push_back(pd[i]);
        rdsec(24'h0010fe, 3);
        prog(24'h003080);
        repeat (20) @(posedge ref_clk);
        foreach (pd[i]) exp_q.push_back(pd[i]);
        rdsec(24'h003080, 3);
        // Locked register two ignores program
        otp_lock_bits = 3'h2;
        pd = '{8'h00, 8'h00, 8'h00};
        prog(24'h002000);
        chk(busy, 8'h00);
        exp_q.push_back(8'hff);
        rdsec(24'h002000, 1);
        // Addresses outside the three registers
        ua = '{24'h004000, 24'h011000, 24'h001100, 24'h0000fe};
        foreach (ua[i]) begin
            repeat (2) exp_q.push_back(8'hff);
            rdsec(ua[i], 2);
        end
        // Read during another cycle is ignored
        busy_in = 1'b1;
        hdr(8'h48, 1'b0, 24'h0010fe);
        wb(8'h00);
        u_sqr_host.xbyte(8'h00, 4'h0, rx);
        chk({4'h0, drv.oe}, 8'h00);
        chk(busy, 8'h01);
        u_sqr_host.stop();
        busy_in = 1'b0;
        // Parameter command refused in SPI
        op(8'hc0, 1'b0);
        wb(8'h33);
        u_sqr_host.stop();
        chk(cfg, 8'h00);
        // Enter QPI: ignored without quad enable, then taken keeping wrap
        op(8'h38, 1'b0);
        u_sqr_host.stop();
        chk(qpi, 8'h00);
        quad_lanes_allow_bit = 1'b1;
        op(8'h38, 1'b0);
        u_sqr_host.stop();
        chk({qpi, cfg}, {3'h0, 1'b1, 2'h0, 2'h1});
        // Every dummy and wrap code, then a wrapping burst past the window
        for (int k = 0; k < 4; k++) begin
            op(8'hc0, 1'b1);
            wb({2'h0, 2'(k), 2'h0, 2'(k)});
            u_sqr_host.stop();
            chk(cfg, {4'h0, 2'(k), 2'(k)});
            len = 8 << k;
            m = 8'(len - 1);
            a = {16'h0012, 8'($random(seed))};
            for (int i = 0; i < len + 2; i++)
                exp_q.push_back(mem({a[23:8], (a[7:0] & ~m) | ((a[7:0] + 8'(i)) & m)}));
            hdr(8'h0c, 1'b1, a);
            repeat (2 + 2 * k) u_sqr_host.unit(4'h0, 4'h0, r4);
            repeat (len + 2) u_sqr_host.rd();
            u_sqr_host.stop();
        end
        // Reset command restores defaults without leaving QPI
        soft_rst = 1'b1;
        @(posedge ref_clk);
        #1 soft_rst = 1'b0;
        repeat (3) @(posedge ref_clk);
        chk({qpi, cfg}, 8'h10);
        op(8'hff, 1'b1);
        u_sqr_host.stop();
        chk(qpi, 8'h00);
        results();
    end
endmodule
`default_nettype wire
